//--- hw/at8_timer.sv
// Asynchronous 8-bit timer: held writes, pending flags, flags, prescaler.
// Assumes an Avalon-MM master on core_clk and a crystal level input
// that is already synchronous to core_clk.
`timescale 1ns/1ps
// Summary of operation
// - Async count write sets counter pending; cleared after copy into counter.
// - Async compare write sets compare pending; cleared after compare is loaded.
// - Async control write sets control pending; cleared after control is loaded.
// - Count reads its read register; compare and control read their holding registers.
// - Async writes go to a holding register, loaded on the second crystal rising edge; sync writes load at once.
// - Each of the three registers has its own independent holding register.
// - Compare matching is blocked while count or compare transfer is in flight.
// - After a timer wake-up, events within one timer clock cycle are lost.
// - Wake-up starts on the timer clock after the interrupt condition.
// - Count read register refreshes on each crystal rise in async mode, each core cycle in sync mode; holds old value in power-save.
// - Async interrupt flags reach the core three cycles after the timer edge.
// - Compare output changes on the timer clock, without core resynchronisation.
// - Interrupt requested only when global enable, its enable and its flag set.
// - Compare flag sets on match; cleared by vector or writing one.
// - Overflow flag sets on overflow; cleared by vector or writing one.
// - Default source is core clock; async select uses crystal, detaches pins.
// - Prescaler gives stop, undivided, 8, 32, 64, 128, 256 and 1024.
// - Prescaler reset bit resets the prescaler phase.
// - Crystal stops in deep sleep; timer registers are lost afterwards.
// - In async mode the prescaler reset bit stays one until reset is done.
module at8_timer (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Core side
  input  wire logic        vector_ack_compare,
  input  wire logic        vector_ack_overflow,
  output logic             irq_compare,
  output logic             irq_overflow,
  output logic             wake_up,
  // Crystal and pins
  input  wire logic        crystal_in,
  output logic             port_detach,
  output logic             compare_out
);
  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  at8_pkg::at8_req_t req;
  logic        wait_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        wr_go;
  logic [7:0]  wdat;
  logic [7:0]  hold_ff [3];
  logic [2:0]  pend_ff;
  logic [7:0]  cnt_ff, cmp_ff, ctl_ff, cnt_rd_ff, mask_ff;
  logic [1:0]  flag_ff;
  logic        async_ff, psr_ff, gie_ff, save_ff, deep_ff;

  assign req = '{read: avs_read, write: avs_write, address: avs_address,
                 byteenable: avs_byteenable, writedata: avs_writedata};
  assign wr_go = req.write && !wait_ff && req.byteenable[0];
  assign wdat  = req.writedata[7:0];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wait_ff <= 1'b1;
    end else if ((req.read || req.write) && wait_ff) begin
      wait_ff <= 1'b0;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  always_comb begin
    nxt_rdata = at8_pkg::READ_ZERO;
    if (req.address == at8_pkg::OFS_COUNT) begin
      nxt_rdata[7:0] = cnt_rd_ff;
    end else if (req.address == at8_pkg::OFS_COMPARE) begin
      nxt_rdata[7:0] = hold_ff[at8_pkg::IDX_CMP];
    end else if (req.address == at8_pkg::OFS_CONTROL) begin
      nxt_rdata[7:0] = hold_ff[at8_pkg::IDX_CTL];
    end else if (req.address == at8_pkg::OFS_STATUS) begin
      nxt_rdata[at8_pkg::POS_ASYNC_SEL] = async_ff;
      nxt_rdata[at8_pkg::POS_PEND_CNT]  = pend_ff[at8_pkg::IDX_CNT];
      nxt_rdata[at8_pkg::POS_PEND_CMP]  = pend_ff[at8_pkg::IDX_CMP];
      nxt_rdata[at8_pkg::POS_PEND_CTL]  = pend_ff[at8_pkg::IDX_CTL];
    end else if (req.address == at8_pkg::OFS_MASK) begin
      nxt_rdata[7:0] = mask_ff;
    end else if (req.address == at8_pkg::OFS_FLAGS) begin
      nxt_rdata[1:0] = flag_ff;
    end else if (req.address == at8_pkg::OFS_SPECIAL) begin
      nxt_rdata[at8_pkg::POS_PSC_RESET] = psr_ff;
    end else if (req.address == at8_pkg::OFS_POWER) begin
      nxt_rdata[at8_pkg::POS_GIE]        = gie_ff;
      nxt_rdata[at8_pkg::POS_SLEEP_SAVE] = save_ff;
      nxt_rdata[at8_pkg::POS_SLEEP_DEEP] = deep_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_ff <= at8_pkg::READ_ZERO;
    end else if (req.read && wait_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Plain control registers
  // ----------------------------------------------------------------
  logic wake_ev;
  logic deep_enter;
  assign deep_enter = wr_go && req.address == at8_pkg::OFS_POWER &&
                      wdat[at8_pkg::POS_SLEEP_DEEP] && !deep_ff;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      async_ff <= 1'b0;
      mask_ff  <= at8_pkg::RST_REG8;
      gie_ff   <= 1'b0;
      deep_ff  <= 1'b0;
    end else if (wr_go) begin
      if (req.address == at8_pkg::OFS_STATUS) begin
        async_ff <= wdat[at8_pkg::POS_ASYNC_SEL];
      end else if (req.address == at8_pkg::OFS_MASK) begin
        mask_ff <= wdat;
      end else if (req.address == at8_pkg::OFS_POWER) begin
        gie_ff  <= wdat[at8_pkg::POS_GIE];
        deep_ff <= wdat[at8_pkg::POS_SLEEP_DEEP];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      save_ff <= 1'b0;
    end else if (wake_ev) begin
      save_ff <= 1'b0;
    end else if (wr_go && req.address == at8_pkg::OFS_POWER) begin
      save_ff <= wdat[at8_pkg::POS_SLEEP_SAVE];
    end
  end

  // ----------------------------------------------------------------
  // Timer clock enables and prescaler
  // ----------------------------------------------------------------
  logic                         xtal_prev_ff, xtal_rise, tdom_en;
  logic [at8_pkg::PSC_WIDTH-1:0] psc_ff, psc_mask;
  logic                         tick;
  at8_pkg::at8_cs_t             cs;

  assign xtal_rise = crystal_in && !xtal_prev_ff && !deep_ff;
  assign tdom_en   = async_ff ? xtal_rise : 1'b1;
  assign cs        = at8_pkg::at8_cs_t'(ctl_ff[2:0]);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      xtal_prev_ff <= 1'b0;
    end else begin
      xtal_prev_ff <= crystal_in;
    end
  end

  always_comb begin
    case (cs)
      at8_pkg::CS_DIV8:    psc_mask = 10'h007;
      at8_pkg::CS_DIV32:   psc_mask = 10'h01F;
      at8_pkg::CS_DIV64:   psc_mask = 10'h03F;
      at8_pkg::CS_DIV128:  psc_mask = 10'h07F;
      at8_pkg::CS_DIV256:  psc_mask = 10'h0FF;
      at8_pkg::CS_DIV1024: psc_mask = 10'h3FF;
      default:             psc_mask = 10'h000;
    endcase
  end
  assign tick = tdom_en && (cs != at8_pkg::CS_STOP) &&
                ((psc_ff & psc_mask) == psc_mask);

  always_ff @(posedge core_clk) begin
    if (srst || (psr_ff && tdom_en)) begin
      psc_ff <= '0;
    end else if (tdom_en) begin
      psc_ff <= psc_ff + 10'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      psr_ff <= 1'b0;
    end else if (wr_go && req.address == at8_pkg::OFS_SPECIAL &&
                 wdat[at8_pkg::POS_PSC_RESET]) begin
      psr_ff <= 1'b1;
    end else if (tdom_en) begin
      psr_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Holding registers and transfer into the timer domain
  // ----------------------------------------------------------------
  logic [2:0] load, busy_ff, clr_s1_ff, clr_s2_ff, reg_wr;
  logic [1:0] edge_ff [3];
  localparam logic [4:0] REG_OFS [3] = '{at8_pkg::OFS_CONTROL,
                                         at8_pkg::OFS_COMPARE,
                                         at8_pkg::OFS_COUNT};

  for (genvar i = 0; i < 3; i++) begin : g_hold
    assign reg_wr[i] = wr_go && req.address == REG_OFS[i];
    assign load[i]   = async_ff ? (busy_ff[i] && xtal_rise &&
                                   edge_ff[i] == at8_pkg::XFER_EDGES_M1)
                                : reg_wr[i];
    always_ff @(posedge core_clk) begin
      if (srst) begin
        hold_ff[i] <= at8_pkg::RST_REG8;
      end else if (reg_wr[i]) begin
        hold_ff[i] <= wdat;
      end
    end
    always_ff @(posedge core_clk) begin
      if (srst) begin
        busy_ff[i] <= 1'b0;
        edge_ff[i] <= 2'h0;
      end else if (reg_wr[i] && async_ff) begin
        busy_ff[i] <= 1'b1;
        edge_ff[i] <= 2'h0;
      end else if (load[i]) begin
        busy_ff[i] <= 1'b0;
      end else if (busy_ff[i] && xtal_rise) begin
        edge_ff[i] <= edge_ff[i] + 2'h1;
      end
    end
    always_ff @(posedge core_clk) begin
      if (srst) begin
        clr_s1_ff[i] <= 1'b0;
        clr_s2_ff[i] <= 1'b0;
      end else begin
        clr_s1_ff[i] <= load[i] && async_ff;
        clr_s2_ff[i] <= clr_s1_ff[i];
      end
    end
    always_ff @(posedge core_clk) begin
      if (srst) begin
        pend_ff[i] <= 1'b0;
      end else if (reg_wr[i] && async_ff) begin
        pend_ff[i] <= 1'b1;
      end else if (clr_s2_ff[i]) begin
        pend_ff[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter, compare and control destinations
  // ----------------------------------------------------------------
  logic     blk_ff, match_ok;
  at8_pkg::at8_evt_t raw_ev;

  assign match_ok = !busy_ff[at8_pkg::IDX_CNT] &&
                    !busy_ff[at8_pkg::IDX_CMP] && !blk_ff;
  assign raw_ev.compare  = tick && match_ok && cnt_ff == cmp_ff;
  assign raw_ev.overflow = tick && !load[at8_pkg::IDX_CNT] && cnt_ff == at8_pkg::CNT_MAX;

  always_ff @(posedge core_clk) begin
    if (srst || deep_enter) begin
      cnt_ff <= at8_pkg::RST_REG8;
      cmp_ff <= at8_pkg::RST_REG8;
      ctl_ff <= at8_pkg::RST_REG8;
    end else begin
      if (load[at8_pkg::IDX_CNT]) begin
        cnt_ff <= async_ff ? hold_ff[at8_pkg::IDX_CNT] : wdat;
      end else if (tick) begin
        cnt_ff <= cnt_ff + 8'h01;
      end
      if (load[at8_pkg::IDX_CMP]) begin
        cmp_ff <= async_ff ? hold_ff[at8_pkg::IDX_CMP] : wdat;
      end
      if (load[at8_pkg::IDX_CTL]) begin
        ctl_ff <= async_ff ? hold_ff[at8_pkg::IDX_CTL] : wdat;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      blk_ff <= 1'b0;
    end else if (load[at8_pkg::IDX_CNT]) begin
      blk_ff <= 1'b1;
    end else if (tick) begin
      blk_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_rd_ff <= at8_pkg::RST_REG8;
    end else if (!save_ff && (async_ff ? xtal_rise : 1'b1)) begin
      cnt_rd_ff <= cnt_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      compare_out <= 1'b0;
    end else if (raw_ev.compare) begin
      case (at8_pkg::at8_com_t'(ctl_ff[at8_pkg::POS_COM_LO +: 2]))
        at8_pkg::COM_TOGGLE: compare_out <= !compare_out;
        at8_pkg::COM_CLEAR:  compare_out <= 1'b0;
        at8_pkg::COM_SET:    compare_out <= 1'b1;
        default:             compare_out <= compare_out;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Flag synchronisation, rearm window and wake-up
  // ----------------------------------------------------------------
  logic [at8_pkg::FLAG_SYNC_CYC-1:0] cmp_dly_ff, ovf_dly_ff;
  logic [1:0] set_ev, clr_w1;
  logic       rearm_ff, wake_pend_ff;
  at8_pkg::at8_evt_t gated;

  assign gated.compare  = raw_ev.compare && !rearm_ff;
  assign gated.overflow = raw_ev.overflow && !rearm_ff;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmp_dly_ff <= '0;
      ovf_dly_ff <= '0;
    end else begin
      cmp_dly_ff <= {cmp_dly_ff[1:0], gated.compare};
      ovf_dly_ff <= {ovf_dly_ff[1:0], gated.overflow};
    end
  end

  assign set_ev[at8_pkg::POS_CMP_IRQ] = async_ff ? cmp_dly_ff[2] : gated.compare;
  assign set_ev[at8_pkg::POS_OVF_IRQ] = async_ff ? ovf_dly_ff[2] : gated.overflow;
  assign clr_w1 = (wr_go && req.address == at8_pkg::OFS_FLAGS) ? wdat[1:0] : 2'b00;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      flag_ff <= 2'b00;
    end else begin
      flag_ff <= set_ev | (flag_ff & ~clr_w1 &
                 ~{vector_ack_compare, vector_ack_overflow});
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_compare  <= 1'b0;
      irq_overflow <= 1'b0;
    end else begin
      irq_compare  <= gie_ff && mask_ff[at8_pkg::POS_CMP_IRQ] &&
                      flag_ff[at8_pkg::POS_CMP_IRQ];
      irq_overflow <= gie_ff && mask_ff[at8_pkg::POS_OVF_IRQ] &&
                      flag_ff[at8_pkg::POS_OVF_IRQ];
    end
  end

  assign wake_ev = wake_pend_ff && tdom_en;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wake_pend_ff <= 1'b0;
      wake_up      <= 1'b0;
      rearm_ff     <= 1'b0;
    end else begin
      wake_up <= wake_ev;
      if (wake_ev) begin
        wake_pend_ff <= 1'b0;
      end else if (save_ff && (irq_compare || irq_overflow)) begin
        wake_pend_ff <= 1'b1;
      end
      if (wake_ev) begin
        rearm_ff <= 1'b1;
      end else if (tdom_en) begin
        rearm_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      port_detach <= 1'b0;
    end else begin
      port_detach <= async_ff;
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  chk_pend_set: assert property (reg_wr[at8_pkg::IDX_CNT] && async_ff |=>
    pend_ff[at8_pkg::IDX_CNT]) else $error("counter pending not set");
  chk_pend_clr: assert property (load[at8_pkg::IDX_CMP] && async_ff &&
    !reg_wr[at8_pkg::IDX_CMP] ##1 !reg_wr[at8_pkg::IDX_CMP] ##1 !reg_wr[at8_pkg::IDX_CMP]
    |=> !pend_ff[at8_pkg::IDX_CMP]) else $error("compare pending not cleared");
  chk_ctl_load: assert property (load[at8_pkg::IDX_CTL] && !deep_enter |=>
    ctl_ff == hold_ff[at8_pkg::IDX_CTL]) else $error("control load wrong");
  chk_match_block: assert property (busy_ff[at8_pkg::IDX_CMP] |->
    !raw_ev.compare) else $error("match during transfer");
  chk_flag_delay: assert property (async_ff && gated.compare ##1 async_ff[*3]
    |=> flag_ff[at8_pkg::POS_CMP_IRQ]) else $error("flag delay wrong");
  chk_irq_gate: assert property (irq_overflow |-> $past(gie_ff) &&
    $past(flag_ff[at8_pkg::POS_OVF_IRQ])) else $error("overflow irq ungated");
  chk_w1c: assert property (clr_w1[at8_pkg::POS_CMP_IRQ] &&
    !set_ev[at8_pkg::POS_CMP_IRQ] |=> !flag_ff[at8_pkg::POS_CMP_IRQ])
    else $error("compare flag not cleared");
  chk_rearm: assert property (rearm_ff |-> !gated.overflow)
    else $error("event passed rearm window");
  chk_psr_hold: assert property (async_ff && psr_ff && !xtal_rise |=>
    psr_ff) else $error("prescaler reset dropped early");

  cov_async_count: cover property (load[at8_pkg::IDX_CNT] && async_ff);
  cov_wake: cover property (wake_up);
  cov_match: cover property (set_ev[at8_pkg::POS_CMP_IRQ]);
endmodule

//--- hw/at8_pkg.sv
// Constants and carrier types for the asynchronous 8-bit timer block.
// Assumes a single core clock; the crystal is sampled as a plain input.
package at8_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_COUNT   = 5'h00;
  localparam logic [4:0] OFS_COMPARE = 5'h04;
  localparam logic [4:0] OFS_CONTROL = 5'h08;
  localparam logic [4:0] OFS_STATUS  = 5'h0C;
  localparam logic [4:0] OFS_MASK    = 5'h10;
  localparam logic [4:0] OFS_FLAGS   = 5'h14;
  localparam logic [4:0] OFS_SPECIAL = 5'h18;
  localparam logic [4:0] OFS_POWER   = 5'h1C;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_ASYNC_SEL  = 3;
  localparam int POS_PEND_CNT   = 2;
  localparam int POS_PEND_CMP   = 1;
  localparam int POS_PEND_CTL   = 0;
  localparam int POS_CMP_IRQ    = 1;
  localparam int POS_OVF_IRQ    = 0;
  localparam int POS_PSC_RESET  = 1;
  localparam int POS_GIE        = 0;
  localparam int POS_SLEEP_SAVE = 1;
  localparam int POS_SLEEP_DEEP = 2;
  localparam int POS_COM_LO     = 4;
  // ----------------------------------------------------------------
  // Indices of the three held registers
  // ----------------------------------------------------------------
  localparam int IDX_CTL = 0;
  localparam int IDX_CMP = 1;
  localparam int IDX_CNT = 2;
  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REG8      = 8'h00;
  localparam logic [7:0] CNT_MAX       = 8'hFF;
  localparam logic [1:0] XFER_EDGES_M1 = 2'h1;
  localparam int         FLAG_SYNC_CYC = 3;
  localparam int         PSC_WIDTH     = 10;
  localparam logic [31:0] READ_ZERO    = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CS_STOP = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV32 = 3'h3,
    CS_DIV64 = 3'h4, CS_DIV128 = 3'h5, CS_DIV256 = 3'h6, CS_DIV1024 = 3'h7
  } at8_cs_t;
  typedef enum logic [1:0] {
    COM_OFF = 2'h0, COM_TOGGLE = 2'h1, COM_CLEAR = 2'h2, COM_SET = 2'h3
  } at8_com_t;
  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } at8_req_t;
  typedef struct packed {
    logic compare;
    logic overflow;
  } at8_evt_t;
endpackage

//--- bench/at8_xtal_model.sv
// Crystal partner model: a slow square wave made on core_clk edges.
// Assumes the design samples crystal_in as a level already on core_clk.
`timescale 1ns/1ps
module at8_xtal_model #(
  parameter int HALF = 6
) (
  // Clock
  input  wire logic core_clk,
  // Control
  input  wire logic run,
  // Crystal pin
  output logic      crystal_in
);
  int cnt = 0;
  // ----------------------------------------------------------------
  // Oscillator, period 2*HALF core cycles, above four to one
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!run) begin
      cnt <= 0;
      crystal_in <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      crystal_in <= !crystal_in;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

//--- bench/test_async_timer8_sync_irq.sv
// Self-checking bench for the asynchronous 8-bit timer.
// Assumes at8_pkg and at8_timer are compiled first.
`timescale 1ns/1ps
module test_async_timer8_sync_irq;
  logic core_clk = 0, srst = 1, avs_read = 0, avs_write = 0, run = 0;
  logic [4:0] avs_address = '0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_writedata = '0, avs_readdata;
  logic avs_waitrequest, ack_cmp = 0, ack_ovf = 0, irq_cmp, irq_ovf, crystal_in, detach, cout;
  logic xtal_q = 0, wake;
  logic [7:0] d;
  int n_mismatch = 0, check_count = 0, rises = 0, r0;
  int mdl[8];
  at8_timer at8_timer_i (.core_clk(core_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .vector_ack_compare(ack_cmp),
    .vector_ack_overflow(ack_ovf), .irq_compare(irq_cmp), .irq_overflow(irq_ovf),
    .wake_up(wake), .crystal_in(crystal_in), .port_detach(detach), .compare_out(cout));
  at8_xtal_model at8_xtal_model_i (.core_clk(core_clk), .run(run), .crystal_in(crystal_in));
  initial forever #20 core_clk = !core_clk;
  always @(posedge core_clk) begin
    xtal_q <= crystal_in;
    if (crystal_in && !xtal_q) rises++;
  end
  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, v};
    avs_write <= 1'b1;
    @(posedge core_clk iff avs_waitrequest === 1'b0);
    avs_write <= 1'b0;
    mdl[a[4:2]] = v;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [4:0] a);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge core_clk iff avs_waitrequest === 1'b0);
    d = avs_readdata[7:0];
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rc(input logic [4:0] a, input logic [7:0] m);
    rd(a);
    chk(d, 8'(mdl[a[4:2]]) & m, "register readback");
  endtask
  task automatic settle(input logic [7:0] m);
    rd(at8_pkg::OFS_STATUS);
    while ((d & m) !== 8'h00) rd(at8_pkg::OFS_STATUS);
  endtask
  task automatic complete_run;
    $display("mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    n_mismatch++;
    complete_run;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    foreach (mdl[i]) mdl[i] = 0;
    void'($urandom(32'h741e));
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rc(at8_pkg::OFS_MASK, 8'hFF);
    rc(at8_pkg::OFS_STATUS, 8'hFF);
    wr(at8_pkg::OFS_MASK, 8'($urandom_range(3)));
    rc(at8_pkg::OFS_MASK, 8'h03);
    wr(at8_pkg::OFS_COMPARE, 8'($urandom));
    rc(at8_pkg::OFS_COMPARE, 8'hFF);
    rd(at8_pkg::OFS_STATUS);
    chk(d, 8'h00, "sync pending");
    wr(at8_pkg::OFS_COUNT, 8'($urandom));
    rc(at8_pkg::OFS_COUNT, 8'hFF);
    wr(at8_pkg::OFS_MASK, 8'h00);
    wr(at8_pkg::OFS_STATUS, 8'h08);
    run <= 1'b1;
    r0 = rises;
    wr(at8_pkg::OFS_COMPARE, 8'h05);
    chk({7'h00, detach}, 8'h01, "pins detached");
    rd(at8_pkg::OFS_STATUS);
    chk(d & 8'h0A, 8'h0A, "compare pending");
    rc(at8_pkg::OFS_COMPARE, 8'hFF);
    wr(at8_pkg::OFS_COUNT, 8'hFE);
    wr(at8_pkg::OFS_CONTROL, 8'h11);
    rd(at8_pkg::OFS_STATUS);
    chk(d & 8'h05, 8'h05, "count and control pending");
    rc(at8_pkg::OFS_CONTROL, 8'hFF);
    settle(8'h02);
    chk(8'(rises - r0 >= 2), 8'h01, "two crystal edges");
    settle(8'h07);
    wr(at8_pkg::OFS_FLAGS, 8'h03);
    wr(at8_pkg::OFS_MASK, 8'h01);
    wr(at8_pkg::OFS_POWER, 8'h01);
    @(posedge core_clk iff irq_ovf === 1'b1);
    rd(at8_pkg::OFS_FLAGS);
    chk(d & 8'h01, 8'h01, "overflow flag");
    wr(at8_pkg::OFS_FLAGS, 8'h01);
    rd(at8_pkg::OFS_FLAGS);
    chk(d & 8'h01, 8'h00, "overflow cleared");
    chk({7'h00, irq_ovf}, 8'h00, "overflow request drops");
    r0 = cout;
    wr(at8_pkg::OFS_MASK, 8'h02);
    @(posedge core_clk iff irq_cmp === 1'b1);
    chk({7'h00, cout}, {7'h00, !r0[0]}, "compare pin toggles");
    ack_cmp <= 1'b1;
    @(posedge core_clk);
    ack_cmp <= 1'b0;
    rd(at8_pkg::OFS_FLAGS);
    chk(d & 8'h02, 8'h00, "vector clears compare");
    wr(at8_pkg::OFS_POWER, 8'h03);
    wr(at8_pkg::OFS_COUNT, 8'h04);
    @(posedge core_clk iff wake === 1'b1);
    rd(at8_pkg::OFS_POWER);
    chk(d & 8'h02, 8'h00, "wake ends power-save");
    @(posedge core_clk iff (crystal_in && !xtal_q));
    wr(at8_pkg::OFS_SPECIAL, 8'h02);
    rd(at8_pkg::OFS_SPECIAL);
    chk(d & 8'h02, 8'h02, "prescaler reset held");
    while (d[1] !== 1'b0) rd(at8_pkg::OFS_SPECIAL);
    chk(d & 8'h02, 8'h00, "prescaler reset done");
    complete_run;
  end
endmodule
